// File: src/bgp_gpio.v
// Purpose: Four bidirectional GPIO ports with pull-high and Port A wake-up.
// Assumes: CPU reaches registers through the data memory strobes below.
// Notes: Read data is registered, so it is valid one cycle after rd_en.
`timescale 1ns/1ps
`include "bgp_regs.vh"
module bgp_gpio (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire halted,
  input wire [3:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  input wire [7:0] pa_in,
  input wire [7:0] pb_in,
  input wire [7:0] pc_in,
  input wire [7:0] pd_in,
  output reg [7:0] pa_out,
  output reg [7:0] pa_oe,
  output reg [7:0] pa_pull,
  output reg [7:0] pb_out,
  output reg [7:0] pb_oe,
  output reg [7:0] pb_pull,
  output reg [7:0] pc_out,
  output reg [7:0] pc_oe,
  output reg [7:0] pc_pull,
  output reg [7:0] pd_out,
  output reg [7:0] pd_oe,
  output reg [7:0] pd_pull,
  output reg wake_req
);
  // ************************************************************
  // Address decode
  // ************************************************************
  function hit;
    input [3:0] a;
    input [3:0] idx;
    begin
      hit = (a == idx);
    end
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  reg [31:0] meta_r;
  reg [31:0] sync_r;
  reg [7:0] pa_prev_r;
  reg [7:0] wake_en_r;
  wire [31:0] pins_in = {pd_in, pc_in, pb_in, pa_in};

  always @(posedge core_clk) begin
    if (!rst_n) begin
      meta_r <= 32'h00000000;
      sync_r <= 32'h00000000;
    end else if (clk_en) begin
      meta_r <= pins_in;
      sync_r <= meta_r;
    end
  end

  // ************************************************************
  // Ports
  // ************************************************************
  wire [31:0] rd_v;
  wire [31:0] o_n;
  wire [31:0] oe_n;
  wire [31:0] pu_n;
  wire [31:0] dq;
  wire [31:0] cq;
  wire [31:0] pq;
  wire [3:0] wr_d;
  wire [3:0] wr_c;
  wire [3:0] wr_p;
  // Tables hold one field per port, port A in the lowest field.
  localparam [31:0] MASKS = {`BGP_MASK_D, `BGP_MASK_C, `BGP_MASK_B,
    `BGP_MASK_A};
  localparam [15:0] DATA_IDX = {`BGP_IDX_DATA_D, `BGP_IDX_DATA_C,
    `BGP_IDX_DATA_B, `BGP_IDX_DATA_A};
  localparam [15:0] DIR_IDX = {`BGP_IDX_DIR_D, `BGP_IDX_DIR_C,
    `BGP_IDX_DIR_B, `BGP_IDX_DIR_A};
  localparam [15:0] PULL_IDX = {`BGP_IDX_PULL_D, `BGP_IDX_PULL_C,
    `BGP_IDX_PULL_B, `BGP_IDX_PULL_A};

  // ************************************************************
  // Write strobes
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gs
      assign wr_d[g] = wr_en && hit(addr, DATA_IDX[4*g+3:4*g]);
      assign wr_c[g] = wr_en && hit(addr, DIR_IDX[4*g+3:4*g]);
      assign wr_p[g] = wr_en && hit(addr, PULL_IDX[4*g+3:4*g]);
    end
  endgenerate

  // ************************************************************
  // Port instances
  // ************************************************************
  generate
    for (g = 0; g < 4; g = g + 1) begin : gp
      bgp_port #(
        .MASK(MASKS[8*g+7:8*g])
      ) i_bgp_port (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .wr_data(wr_d[g]),
        .wr_dir(wr_c[g]),
        .wr_pull(wr_p[g]),
        .wdata(wdata),
        .pin_sync(sync_r[8*g+7:8*g]),
        .data_q(dq[8*g+7:8*g]),
        .dir_q(cq[8*g+7:8*g]),
        .pull_q(pq[8*g+7:8*g]),
        .read_val(rd_v[8*g+7:8*g]),
        .pin_out_nxt(o_n[8*g+7:8*g]),
        .pin_oe_nxt(oe_n[8*g+7:8*g]),
        .pull_on_nxt(pu_n[8*g+7:8*g])
      );
    end
  endgenerate

  // ************************************************************
  // Read mux
  // ************************************************************
  reg [7:0] rd_mux;
  always @* begin
    case (addr)
      `BGP_IDX_WAKE_A: rd_mux = wake_en_r;
      `BGP_IDX_PULL_A: rd_mux = pq[7:0];
      `BGP_IDX_DATA_A: rd_mux = rd_v[7:0];
      `BGP_IDX_DIR_A: rd_mux = cq[7:0];
      `BGP_IDX_PULL_B: rd_mux = pq[15:8];
      `BGP_IDX_DATA_B: rd_mux = rd_v[15:8];
      `BGP_IDX_DIR_B: rd_mux = cq[15:8];
      `BGP_IDX_PULL_C: rd_mux = pq[23:16];
      `BGP_IDX_DATA_C: rd_mux = rd_v[23:16];
      `BGP_IDX_DIR_C: rd_mux = cq[23:16];
      `BGP_IDX_PULL_D: rd_mux = pq[31:24];
      `BGP_IDX_DATA_D: rd_mux = rd_v[31:24];
      `BGP_IDX_DIR_D: rd_mux = cq[31:24];
      default: rd_mux = 8'h00;
    endcase
  end

  // ************************************************************
  // Wake-up
  // ************************************************************
  // Edge detection uses the synchronised level, never the first stage.
  wire [7:0] pa_fall = pa_prev_r & ~sync_r[7:0] & wake_en_r;
  wire wr_wake = wr_en && hit(addr, `BGP_IDX_WAKE_A);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      wake_en_r <= `BGP_RST_WAKE;
      pa_prev_r <= 8'h00;
      wake_req <= 1'b0;
    end else if (clk_en) begin
      if (wr_wake) begin
        wake_en_r <= wdata & `BGP_MASK_A;
      end
      pa_prev_r <= sync_r[7:0];
      wake_req <= halted && (|pa_fall);
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  // Read data is captured on the strobe edge and then held, so the CPU
  // may pick it up at any time before its next read.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (clk_en && rd_en) begin
      rdata <= rd_mux;
    end
  end

  // Pin controls pass one flop so the pads never see decode glitches.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pa_out <= 8'h00;
      pa_oe <= 8'h00;
      pa_pull <= 8'h00;
      pb_out <= 8'h00;
      pb_oe <= 8'h00;
      pb_pull <= 8'h00;
      pc_out <= 8'h00;
      pc_oe <= 8'h00;
      pc_pull <= 8'h00;
      pd_out <= 8'h00;
      pd_oe <= 8'h00;
      pd_pull <= 8'h00;
    end else if (clk_en) begin
      pa_out <= o_n[7:0];
      pa_oe <= oe_n[7:0];
      pa_pull <= pu_n[7:0];
      pb_out <= o_n[15:8];
      pb_oe <= oe_n[15:8];
      pb_pull <= pu_n[15:8];
      pc_out <= o_n[23:16];
      pc_oe <= oe_n[23:16];
      pc_pull <= pu_n[23:16];
      pd_out <= o_n[31:24];
      pd_oe <= oe_n[31:24];
      pd_pull <= pu_n[31:24];
    end
  end
endmodule

// File: src/bgp_regs.vh
// Purpose: Register indexes, field limits and reset values of the GPIO ports.
// Assumes: Eight-bit special-purpose data memory bus of the CPU core.
// Notes: Offsets are local indexes inside the GPIO address window.
`ifndef BGP_REGS_VH
`define BGP_REGS_VH
// ************************************************************
// Register indexes
// ************************************************************
`define BGP_ADDR_W 4
`define BGP_IDX_WAKE_A 4'h0
`define BGP_IDX_PULL_A 4'h1
`define BGP_IDX_DATA_A 4'h2
`define BGP_IDX_DIR_A 4'h3
`define BGP_IDX_PULL_B 4'h4
`define BGP_IDX_DATA_B 4'h5
`define BGP_IDX_DIR_B 4'h6
`define BGP_IDX_PULL_C 4'h7
`define BGP_IDX_DATA_C 4'h8
`define BGP_IDX_DIR_C 4'h9
`define BGP_IDX_PULL_D 4'ha
`define BGP_IDX_DATA_D 4'hb
`define BGP_IDX_DIR_D 4'hc
// ************************************************************
// Implemented bits and reset values
// ************************************************************
`define BGP_MASK_A 8'h9f
`define BGP_MASK_B 8'hff
`define BGP_MASK_C 8'hff
`define BGP_MASK_D 8'h0f
`define BGP_RST_DATA 8'hff
`define BGP_RST_DIR 8'hff
`define BGP_RST_PULL 8'h00
`define BGP_RST_WAKE 8'h00
`endif

// File: src/bgp_port.v
// Purpose: One eight-bit port: output latch, direction, pull-high, read mux.
// Assumes: Pin input is already synchronised by the caller.
// Notes: Bits outside MASK never store and read as zero.
`timescale 1ns/1ps
`include "bgp_regs.vh"
module bgp_port #(
  parameter [7:0] MASK = 8'hff
) (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire wr_data,
  input wire wr_dir,
  input wire wr_pull,
  input wire [7:0] wdata,
  input wire [7:0] pin_sync,
  output wire [7:0] data_q,
  output wire [7:0] dir_q,
  output wire [7:0] pull_q,
  output wire [7:0] read_val,
  output wire [7:0] pin_out_nxt,
  output wire [7:0] pin_oe_nxt,
  output wire [7:0] pull_on_nxt
);
  reg [7:0] data_r;
  reg [7:0] dir_r;
  reg [7:0] pull_r;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      data_r <= `BGP_RST_DATA & MASK;
      dir_r <= `BGP_RST_DIR & MASK;
      pull_r <= `BGP_RST_PULL;
    end else if (clk_en) begin
      if (wr_data) begin
        data_r <= wdata & MASK;
      end
      if (wr_dir) begin
        dir_r <= wdata & MASK;
      end
      if (wr_pull) begin
        pull_r <= wdata & MASK;
      end
    end
  end

  assign data_q = data_r;
  assign dir_q = dir_r;
  assign pull_q = pull_r;
  // Output pins report the latch, input pins the live level.
  assign read_val = ((dir_r & pin_sync) | (~dir_r & data_r)) & MASK;
  assign pin_out_nxt = data_r;
  assign pin_oe_nxt = ~dir_r & MASK;
  assign pull_on_nxt = pull_r & dir_r & MASK;
endmodule

// File: testbench/bgp_gpio_sva.sv
// Purpose: Port-level checks of the GPIO ports.
// Assumes: Pin outputs lag a write by two enabled edges.
// Notes: Watches port A and the read path.
`timescale 1ns/1ps
module bgp_gpio_sva (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire halted,
  input wire [3:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire [7:0] pa_out,
  input wire [7:0] pa_oe,
  input wire [7:0] pa_pull,
  input wire wake_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire wa = clk_en && wr_en;
  wire ra = clk_en && rd_en;
  AST_DIR: assert property (wa && addr == 4'h3 ##1 clk_en
    |=> pa_oe == (~$past(wdata, 2) & 8'h9f)) else $error("oe");
  AST_OUT: assert property (wa && addr == 4'h2 ##1 clk_en
    |=> pa_out == ($past(wdata, 2) & 8'h9f)) else $error("out");
  AST_HOLD: assert property ((rst_n && !(wa && addr == 4'h2)) [*2]
    |=> $stable(pa_out)) else $error("hold");
  AST_PULL: assert property (wa && addr == 4'h1 ##1 clk_en
    |=> pa_pull == ($past(wdata, 2) & ~pa_oe & 8'h9f)) else $error("pu");
  AST_RD_DIR: assert property (ra && addr == 4'h3
    |=> rdata == (~pa_oe & 8'h9f)) else $error("rd dir");
  AST_RD_OUT: assert property (ra && addr == 4'h2
    |=> ((rdata ^ pa_out) & pa_oe) == 8'h00) else $error("rd out");
  AST_UNMAP: assert property (ra && addr > 4'hc
    |=> rdata == 8'h00) else $error("unmap");
  AST_MASK_A: assert property (ra && addr < 4'h4
    |=> rdata[6:5] == 2'b00) else $error("mask");
  AST_WAKE: assert property (wake_req |-> $past(halted))
    else $error("wake");
endmodule
bind bgp_gpio bgp_gpio_sva i_bgp_gpio_sva (.*);

// File: testbench/bgp_pins.sv
// Purpose: Switches and loose wires outside all four ports.
// Assumes: Bits packed d, c, b, a from the top.
// Notes: An undriven pin without pull-high toggles each cycle.
`timescale 1ns/1ps
module bgp_pins (
  input wire core_clk,
  input wire [31:0] out,
  input wire [31:0] oe,
  input wire [31:0] pull,
  input wire [31:0] drv,
  input wire [31:0] drv_en,
  output wire [31:0] pin
);
  reg [31:0] flt_r = 32'h0;
  always @(posedge core_clk) flt_r <= ~flt_r;
  assign pin = oe & out | ~oe & (drv_en & drv | ~drv_en & (pull | flt_r));
endmodule

// File: testbench/tb_bgp_gpio.sv
// Purpose: Random and corner tests of the GPIO ports.
// Assumes: Pins settle within three enabled edges.
// Notes: Floating input bits are left out of read checks.
`timescale 1ns/1ps
module tb_bgp_gpio;
  reg core_clk = 0, rst_n = 0, clk_en = 1, halted = 0, wr_en = 0, rd_en = 0;
  reg [3:0] addr = 0;
  reg [7:0] wdata = 0;
  reg [7:0] rg [0:15];
  reg [31:0] drv = 0, den = 0;
  wire [7:0] rdata, pa_out, pa_oe, pa_pull, pb_out, pb_oe, pb_pull;
  wire [7:0] pc_out, pc_oe, pc_pull, pd_out, pd_oe, pd_pull;
  wire [31:0] pin;
  wire wake_req;
  wire [31:0] o_all = {pd_out, pc_out, pb_out, pa_out};
  wire [31:0] oe_all = {pd_oe, pc_oe, pb_oe, pa_oe};
  wire [31:0] pu_all = {pd_pull, pc_pull, pb_pull, pa_pull};
  integer errors = 0, checks_done = 0, cyc = 0, i, j;
  bgp_gpio i_bgp_gpio (.pa_in(pin[7:0]), .pb_in(pin[15:8]),
    .pc_in(pin[23:16]), .pd_in(pin[31:24]), .*);
  bgp_pins i_bgp_pins (.core_clk(core_clk), .drv(drv), .drv_en(den),
    .out({pd_out, pc_out, pb_out, pa_out}), .oe({pd_oe, pc_oe, pb_oe, pa_oe}),
    .pull({pd_pull, pc_pull, pb_pull, pa_pull}), .pin(pin));
  initial forever #20 core_clk = ~core_clk;
  function [7:0] mk(input [3:0] a);
    mk = a < 4 ? 8'h9f : a < 10 ? 8'hff : a < 13 ? 8'h0f : 8'h00;
  endfunction
  task stop_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] e, input [7:0] k);
    checks_done = checks_done + 1;
    if (((got ^ e) & k) !== 8'h00) begin
      errors = errors + 1;
      $display("ERROR %0t got %h exp %h", $time, got, e);
    end
  endtask
  task outs;
    integer p;
    for (p = 0; p < 4; p = p + 1) begin
      chk(o_all[8*p +: 8], rg[3*p+2], 8'hff);
      chk(oe_all[8*p +: 8], ~rg[3*p+3] & mk(3*p+3), 8'hff);
      chk(pu_all[8*p +: 8], rg[3*p+1] & rg[3*p+3], 8'hff);
    end
  endtask
  task acc(input w, input r, input [3:0] a, input [7:0] d, input c);
    reg [7:0] e, k, dr, x, n;
    @(posedge core_clk);
    {wr_en, rd_en, addr, wdata, clk_en} <= {w, r, a, d, c};
    @(posedge core_clk);
    {wr_en, rd_en, clk_en} <= 3'b001;
    #1 e = rg[a];
    k = 8'hff;
    if (a % 3 == 2 && a < 12) begin
      {dr, x, n} = {rg[a + 1], drv[a / 3 * 8 +: 8], den[a / 3 * 8 +: 8]};
      e = (rg[a] & ~dr | dr & (x | ~n)) & mk(a);
      k = ~dr | n | rg[a - 1] | ~mk(a);
    end
    if (c && r) chk(rdata, e, k);
    if (c && w) rg[a] = d & mk(a);
  endtask
  task wk(input h, input [2:0] b, input e);
    reg s;
    @(posedge core_clk);
    {halted, drv[7:0], den[7:0]} <= {h, 16'hffff};
    repeat (4) @(posedge core_clk);
    drv[b] <= 1'b0;
    s = 0;
    repeat (6) @(posedge core_clk) #1 s = s | (wake_req === 1'b1);
    chk({7'h0, s}, {7'h0, e}, 8'hff);
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      errors = errors + 1;
      stop_test;
    end
  end
  initial begin
    i = $urandom(32'h32358333);
    for (i = 0; i < 16; i = i + 1) rg[i] = i > 1 && i % 3 != 1 ? mk(i) : 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    for (j = 0; j < 40; j = j + 1) begin
      if (j > 0) repeat (4) acc(1, 0, $urandom % 16, $urandom, $urandom % 8);
      @(posedge core_clk);
      {halted, drv, den} <= {$urandom, $urandom, $urandom};
      repeat (3) @(posedge core_clk);
      #1 outs;
      for (i = 0; i < 16; i = i + 1) acc(0, 1, i, 0, 1);
    end
    acc(1, 1, 4'h3, 8'hff, 1);
    acc(1, 1, 4'h0, 8'h11, 1);
    wk(1, 0, 1);
    wk(1, 1, 0);
    wk(0, 4, 0);
    wk(1, 4, 1);
    stop_test;
  end
endmodule
